// File: rtl/asc_pkg.sv
// package: constants, states and carrier structs for the serial conversion controller
package asc_pkg;

  // ************************************************************
  // clocking and timing
  // ************************************************************
  localparam int unsigned CLK_HZ            = 50000000;
  localparam int unsigned INT_OSC_HZ        = 307200;   // internal conversion clock
  localparam int unsigned INT_SCK_HZ        = 38400;    // internal shift clock
  localparam int unsigned EXT_SCK_DIV       = 8;        // external conv clock / 8
  localparam int unsigned CONV_PERIODS      = 41036;    // conversion clock periods per conversion
  localparam int unsigned XFER_BITS         = 24;       // shift periods per result
  localparam int unsigned XFER_CONV_PERIODS = XFER_BITS * EXT_SCK_DIV; // 192
  // cycles per internal oscillator period, rounded down
  localparam int unsigned OSC_DIV  = CLK_HZ / INT_OSC_HZ;
  // cycles per half period of internal shift clock
  localparam int unsigned ISCK_HALF = CLK_HZ / (2 * INT_SCK_HZ);
  // internal oscillator ticks past this count with no pin toggle before external clock is dropped
  localparam int unsigned EXT_LOSS_TICKS = 4;

  // ************************************************************
  // channel selection layout (filled in from full specification)
  // ************************************************************
  localparam int unsigned SEL_W       = 8;
  localparam int unsigned CH_W        = 4;
  localparam int unsigned SEL_EN_BIT  = 7;   // selection word valid
  localparam int unsigned SEL_SGL_BIT = 6;   // single-ended when set
  localparam int unsigned SEL_ODD_BIT = 5;   // swap pair polarity
  localparam int unsigned SEL_ADR_LSB = 0;   // pair address, three bits
  localparam int unsigned SEL_ADR_W   = 3;
  localparam logic [CH_W-1:0] RST_POS_CH = 4'h0;
  localparam logic [CH_W-1:0] RST_NEG_CH = 4'h1;

  // ************************************************************
  // result layout
  // ************************************************************
  localparam int unsigned RES_W      = 24;
  localparam int unsigned CODE_W     = 16;
  localparam logic [1:0]  STAT_OVER  = 2'h3;
  localparam logic [1:0]  STAT_UNDER = 2'h0;
  localparam logic [1:0]  STAT_POS   = 2'h2;
  localparam logic [1:0]  STAT_NEG   = 2'h1;

  typedef enum logic [1:0] {
    ASC_CONV  = 2'h0,
    ASC_SLEEP = 2'h1,
    ASC_XFER  = 2'h2
  } asc_state_t;

  // mux routing toward the analog front end
  typedef struct packed {
    logic [CH_W-1:0] pos_ch;
    logic [CH_W-1:0] neg_ch;
    logic            neg_is_shared;
  } asc_route_t;

  // one finished conversion sample from the modulator
  typedef struct packed {
    logic [CODE_W-1:0] code;
    logic              over;
    logic              under;
  } asc_sample_t;

endpackage : asc_pkg

// File: rtl/asc_fifo.sv
// buffer: no logic here, the sample fifo module sits beside the controller in asc_ctrl.sv

// File: rtl/asc_ctrl.sv
// top: conversion, sleep and serial transfer control of a multi-channel converter
// How it works
// - after conversion, sleep and stay asleep while chip select is high
// - chip select low wakes converter and enables serial input and output
// - chip select rising during result shift aborts and starts new conversion
// - serial output is released whenever chip select is high
// - outside transfer, serial output high while converting, low when done
// - shift clock pin level at reset and chip select fall picks clock mode
// - internal mode drives shift clock at 38.4 kHz or conversion clock / 8
// - result transfer is 24 shift periods, 192 conversion periods internally
// - static frequency pin uses internal 307.2 kHz oscillator
// - toggling frequency pin overrides internal oscillator while it rises at least every 4 oscillator periods, up to 4000 kHz
// - channel select word shifted in on serial input during result transfer
// - first conversion after new selection is valid, no discarded conversions
// - single-ended configurations route shared input as negative input
// - each of sixteen inputs usable single-ended or in a differential pair
// - over and under range give distinct result codes
// - during transfer, serial output carries result bits
// - output changes on falling shift edge, input captured on rising edge
// - transfer ends after 24 bits or chip select rise, then converts
// - chip select rise before first rising shift edge returns to sleep
// - after reset, clear state and convert channel 0 positive, 1 negative
module asc_ctrl #(
  parameter int unsigned CONV_PERIODS = asc_pkg::CONV_PERIODS,
  parameter int unsigned FIFO_DEPTH   = 16
) (
  input  wire logic                   mclk_in,
  input  wire logic                   resetn_in,
  input  wire logic                   cs_n_in,
  input  wire logic                   sck_in,
  output logic                        sck_out,
  output logic                        sck_oe_n_out,
  input  wire logic                   serial_in_pin_in,
  output logic                        serial_out_pin_out,
  output logic                        serial_out_oe_n_out,
  input  wire logic                   conversion_clock_ctrl_pin_in,
  input  wire asc_pkg::asc_sample_t   sample_in,
  input  wire logic                   sample_valid_in,
  output logic                        sample_ready_out,
  output asc_pkg::asc_route_t         route_out,
  output logic                        converting_out,
  output logic                        sleep_out,
  output logic                        ext_clk_out,
  output logic                        int_sck_mode_out
);
  initial begin
    if (CONV_PERIODS < 2) $error("conversion length too short");
  end

  // ************************************************************
  // sample buffer between modulator and controller
  // ************************************************************
  localparam int unsigned SW = $bits(asc_pkg::asc_sample_t);
  logic [SW-1:0] fifo_rdata;
  logic          fifo_rvalid;
  logic          fifo_rready;
  logic          fifo_wready;
  asc_pkg::asc_sample_t fifo_sample;

  asc_fifo #(.WIDTH(SW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk_in    (mclk_in),
    .resetn_in  (resetn_in),
    .wdata_in   (sample_in),
    .wvalid_in  (sample_valid_in),
    .wready_out (fifo_wready),
    .rdata_out  (fifo_rdata),
    .rvalid_out (fifo_rvalid),
    .rready_in  (fifo_rready)
  );
  assign fifo_sample = asc_pkg::asc_sample_t'(fifo_rdata);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    asc_pkg::asc_state_t                    fsm;
    logic                                   cs_q;
    logic                                   sck_q;
    logic                                   f0_q;
    logic                                   int_mode;
    logic                                   started;
    logic [$clog2(asc_pkg::OSC_DIV+1)-1:0]  osc_cnt;
    logic [$clog2(asc_pkg::EXT_LOSS_TICKS+1)-1:0] loss_cnt;
    logic                                   ext_clk;
    logic [$clog2(CONV_PERIODS+1)-1:0]      conv_cnt;
    logic [$clog2(asc_pkg::ISCK_HALF+1)-1:0] isck_cnt;
    logic [2:0]                             ediv_cnt;
    logic                                   sck_o;
    logic [4:0]                             bit_cnt;
    logic [asc_pkg::RES_W-1:0]              shreg;
    logic [asc_pkg::SEL_W-1:0]              sel_sh;
    logic [asc_pkg::RES_W-1:0]              result;
    logic                                   serial_out_pin;
    logic                                   sdo_oe_n;
    logic                                   sample_rd;
    logic                                   sck_oe_n;
    logic                                   busy;
    logic                                   asleep;
    logic                                   booted;
    asc_pkg::asc_route_t                    route;
  } asc_st_t;

  asc_st_t st;
  asc_st_t next_st;

  // ************************************************************
  // derived events
  // ************************************************************
  logic cs_fall;
  logic cs_rise;
  logic osc_tick;
  logic f0_edge;
  logic conv_tick;
  logic sck_now;
  logic sck_rise;
  logic sck_fall;
  asc_pkg::asc_route_t sel_route;

  assign cs_fall  = st.cs_q && !cs_n_in;
  assign cs_rise  = !st.cs_q && cs_n_in;
  assign osc_tick = st.osc_cnt == ($bits(st.osc_cnt))'(asc_pkg::OSC_DIV - 1);
  assign f0_edge  = conversion_clock_ctrl_pin_in && !st.f0_q && st.booted; // no false edge out of reset
  assign conv_tick = st.ext_clk ? f0_edge : osc_tick;
  assign sck_now  = st.int_mode ? st.sck_o : sck_in;
  assign sck_rise = sck_now && !st.sck_q;
  assign sck_fall = !sck_now && st.sck_q;

  // selection word decode, route toward mux
  always_comb begin
    sel_route = st.route;
    if (st.sel_sh[asc_pkg::SEL_EN_BIT]) begin
      if (st.sel_sh[asc_pkg::SEL_SGL_BIT]) begin
        sel_route.pos_ch = {st.sel_sh[asc_pkg::SEL_ADR_LSB +: asc_pkg::SEL_ADR_W],
                            st.sel_sh[asc_pkg::SEL_ODD_BIT]};
        sel_route.neg_ch = '0;
        sel_route.neg_is_shared = 1'b1;
      end else begin
        sel_route.pos_ch = {st.sel_sh[asc_pkg::SEL_ADR_LSB +: asc_pkg::SEL_ADR_W],
                            st.sel_sh[asc_pkg::SEL_ODD_BIT]};
        sel_route.neg_ch = {st.sel_sh[asc_pkg::SEL_ADR_LSB +: asc_pkg::SEL_ADR_W],
                            !st.sel_sh[asc_pkg::SEL_ODD_BIT]};
        sel_route.neg_is_shared = 1'b0;
      end
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;
    next_st.cs_q = cs_n_in;
    next_st.f0_q = conversion_clock_ctrl_pin_in;
    next_st.sck_q = sck_now;
    next_st.sample_rd = 1'b0;
    next_st.booted = 1'b1;

    // conversion clock source: external once pin toggles, internal when static
    next_st.osc_cnt = osc_tick ? '0 : st.osc_cnt + 1'b1;
    if (f0_edge) begin
      next_st.ext_clk  = 1'b1;
      next_st.loss_cnt = '0;
    end else if (osc_tick) begin
      if (st.loss_cnt == ($bits(st.loss_cnt))'(asc_pkg::EXT_LOSS_TICKS)) begin
        next_st.ext_clk = 1'b0;
      end else begin
        next_st.loss_cnt = st.loss_cnt + 1'b1;
      end
    end

    // shift clock mode strapped on the first cycle after reset and at each chip select fall
    if (cs_fall || !st.booted) next_st.int_mode = sck_in;

    case (st.fsm)
      asc_pkg::ASC_CONV: begin
        next_st.serial_out_pin = 1'b1;
        if (conv_tick) next_st.conv_cnt = st.conv_cnt + 1'b1;
        if (st.conv_cnt == ($bits(st.conv_cnt))'(CONV_PERIODS) && fifo_rvalid) begin
          // sample taken straight from this conversion, none discarded
          next_st.sample_rd = 1'b1;
          next_st.result = {(fifo_sample.over  ? asc_pkg::STAT_OVER :
                             fifo_sample.under ? asc_pkg::STAT_UNDER :
                             fifo_sample.code[asc_pkg::CODE_W-1] ? asc_pkg::STAT_NEG : asc_pkg::STAT_POS),
                            fifo_sample.over  ? {asc_pkg::CODE_W{1'b0}} :
                            fifo_sample.under ? {asc_pkg::CODE_W{1'b1}} : fifo_sample.code,
                            6'h00};
          next_st.fsm = asc_pkg::ASC_SLEEP;
        end
      end
      asc_pkg::ASC_SLEEP: begin
        next_st.serial_out_pin = 1'b0;
        if (!cs_n_in) begin
          next_st.fsm      = asc_pkg::ASC_XFER;
          next_st.shreg    = st.result;
          next_st.bit_cnt  = '0;
          next_st.started  = 1'b0;
          next_st.sel_sh   = '0;
          next_st.sck_o    = 1'b1;
          next_st.isck_cnt = '0;
          next_st.ediv_cnt = '0;
        end
      end
      asc_pkg::ASC_XFER: begin
        // internal shift clock: half period of ISCK_HALF master clock cycles or conv clock / 8
        if (st.int_mode) begin
          if (st.ext_clk) begin
            if (f0_edge) begin
              next_st.ediv_cnt = st.ediv_cnt + 1'b1;
              if (st.ediv_cnt[1:0] == 2'h3) next_st.sck_o = !st.sck_o;
            end
          end else if (st.isck_cnt == ($bits(st.isck_cnt))'(asc_pkg::ISCK_HALF - 1)) begin
            next_st.isck_cnt = '0;
            next_st.sck_o = !st.sck_o;
          end else begin
            next_st.isck_cnt = st.isck_cnt + 1'b1;
          end
        end
        if (!st.started) next_st.serial_out_pin = st.shreg[asc_pkg::RES_W-1];
        if (sck_fall && st.started) begin
          next_st.serial_out_pin   = st.shreg[asc_pkg::RES_W-1];
        end
        if (sck_rise) begin
          next_st.started = 1'b1;
          // later bits only clock the result out, the word stays as first shifted
          if (st.bit_cnt < 5'(asc_pkg::SEL_W)) begin
            next_st.sel_sh = {st.sel_sh[asc_pkg::SEL_W-2:0], serial_in_pin_in};
          end
          next_st.shreg   = {st.shreg[asc_pkg::RES_W-2:0], 1'b0};
          next_st.bit_cnt = st.bit_cnt + 1'b1;
        end
        if (cs_n_in && !st.started) begin
          next_st.fsm = asc_pkg::ASC_SLEEP;
          next_st.sck_o = 1'b1;
        end else if (cs_n_in ||
                     (st.bit_cnt == 5'(asc_pkg::XFER_BITS) && (!st.int_mode || st.sck_o))) begin
          next_st.fsm      = asc_pkg::ASC_CONV;
          next_st.conv_cnt = '0;
          if (st.bit_cnt >= 5'(asc_pkg::SEL_W)) next_st.route = sel_route; // partial word keeps old route
          next_st.sck_o    = 1'b1;
        end
      end
      default: next_st.fsm = asc_pkg::ASC_CONV;
    endcase

    next_st.sdo_oe_n = cs_n_in;
    next_st.sck_oe_n = !(next_st.int_mode && next_st.fsm == asc_pkg::ASC_XFER && !cs_n_in);
    next_st.busy     = next_st.fsm == asc_pkg::ASC_CONV;
    next_st.asleep   = next_st.fsm == asc_pkg::ASC_SLEEP && cs_n_in;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      st <= '0;
      st.cs_q  <= 1'b1;
      st.sck_o <= 1'b1;
      st.serial_out_pin   <= 1'b1;
      st.sdo_oe_n <= 1'b1;
      st.sck_oe_n <= 1'b1;
      st.busy     <= 1'b1;
      st.route <= '{pos_ch: asc_pkg::RST_POS_CH, neg_ch: asc_pkg::RST_NEG_CH, neg_is_shared: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign fifo_rready = next_st.sample_rd;

  // ************************************************************
  // outputs
  // ************************************************************
  assign sck_out             = st.sck_o;
  assign sck_oe_n_out        = st.sck_oe_n;
  assign serial_out_pin_out  = st.serial_out_pin;
  assign serial_out_oe_n_out = st.sdo_oe_n;
  assign sample_ready_out    = fifo_wready;
  assign route_out           = st.route;
  assign converting_out      = st.busy;
  assign sleep_out           = st.asleep;
  assign ext_clk_out         = st.ext_clk;
  assign int_sck_mode_out    = st.int_mode;
endmodule // asc_ctrl

// ************************************************************
// sample fifo
// ************************************************************
module asc_fifo #(
  parameter int unsigned WIDTH = 24,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             mclk_in,
  input  wire logic             resetn_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  input  wire logic             wvalid_in,
  output logic                  wready_out,
  output logic [WIDTH-1:0]      rdata_out,
  output logic                  rvalid_out,
  input  wire logic             rready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  end

  // ready is registered so the controller can pass it straight out
  typedef struct packed {
    logic [AW:0] wptr;
    logic [AW:0] rptr;
    logic        wready;
  } asc_fifo_st_t;

  logic [WIDTH-1:0] mem [DEPTH];
  asc_fifo_st_t     st;
  asc_fifo_st_t     next_st;
  logic             do_wr;
  logic             do_rd;

  assign wready_out = st.wready;
  assign rvalid_out = st.wptr != st.rptr;
  assign rdata_out  = mem[st.rptr[AW-1:0]];
  assign do_wr      = wvalid_in && st.wready;
  assign do_rd      = rvalid_out && rready_in;

  always_comb begin
    next_st = st;
    if (do_wr) next_st.wptr = st.wptr + 1'b1;
    if (do_rd) next_st.rptr = st.rptr + 1'b1;
    next_st.wready = (next_st.wptr - next_st.rptr) != (AW+1)'(DEPTH);
  end

  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      st        <= '0;
      st.wready <= 1'b1;
    end else begin
      st <= next_st;
    end
    if (do_wr) mem[st.wptr[AW-1:0]] <= wdata_in;
  end
endmodule // asc_fifo

// File: tb/asc_host_model.sv
// host model: chip select, shift clock and selection word on the far side
module asc_host_model (
  input  wire logic mclk_in,
  input  wire logic sck_pin_in,
  input  wire logic sdo_pin_in,
  output logic      cs_n_out,
  output logic      sck_drv_out,
  output logic      sck_oe_n_out,
  output logic      sdi_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_out = 1'b1;
    sck_drv_out = 1'b1;
    sck_oe_n_out = 1'b1;
    sdi_out = 1'b0;
  end
  // ****************
  // host transfers
  // ****************
  task automatic hold_cs(input logic lvl, output logic serial_out_pin);
    @(negedge mclk_in);
    cs_n_out = lvl;
    repeat (4) @(negedge mclk_in);
    serial_out_pin = sdo_pin_in;
  endtask
  task automatic xfer(input bit ext, input logic [7:0] sel, input int nb, output logic [23:0] w, output int cyc);
    int n;
    logic prev;
    w = 24'h0;
    cyc = 0;
    n = 0;
    @(negedge mclk_in);
    sck_oe_n_out = !ext;  // low strap picks external clock
    sck_drv_out = 1'b0;
    sdi_out = sel[7];
    repeat (4) @(negedge mclk_in);
    cs_n_out = 1'b0;
    prev = sck_pin_in;
    while (n < nb && cyc < 20000) begin
      @(negedge mclk_in);
      cyc++;
      if (ext && cyc % 8 == 0) sck_drv_out = ~sck_drv_out;  // 3.125 MHz, under the limit
      if (sck_pin_in && !prev) begin
        w = {w[22:0], sdo_pin_in};
        n++;
      end
      if (!sck_pin_in && prev) sdi_out = (n < 8) ? sel[7 - n] : ~sdi_out;
      prev = sck_pin_in;
    end
    repeat (8) @(negedge mclk_in);
    cs_n_out = 1'b1;
    sck_oe_n_out = 1'b1;
    sdi_out = ~sdi_out;  // released line keeps moving
    @(negedge mclk_in);
  endtask
endmodule // asc_host_model

// File: tb/asc_ctrl_assertions.sv
// checker: port timing of the conversion controller
module asc_ctrl_assertions #(
  parameter int unsigned CONV_PERIODS = 10,
  parameter int unsigned FIFO_DEPTH   = 16
) (
  input wire logic                mclk_in,
  input wire logic                resetn_in,
  input wire logic                cs_n_in,
  input wire logic                sck_in,
  input wire logic                sck_oe_n_out,
  input wire logic                serial_out_pin_out,
  input wire logic                serial_out_oe_n_out,
  input wire asc_pkg::asc_route_t route_out,
  input wire logic                converting_out,
  input wire logic                sleep_out,
  input wire logic                int_sck_mode_out
);
  logic       sck_q;
  logic [4:0] rises;
  wire        in_xfer = !sleep_out && !converting_out;
  // ****************
  // rising shift edges within one transfer
  // ****************
  always_ff @(posedge mclk_in) begin
    sck_q <= sck_in;
    if (!resetn_in || !in_xfer) rises <= 5'h0;
    else if (sck_in && !sck_q) rises <= rises + 5'h1;
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_polled;
    (!cs_n_in && converting_out) [*2];
  endsequence
  sequence s_cs_up;
    in_xfer && cs_n_in;
  endsequence
  property p_hold; sleep_out && cs_n_in |=> sleep_out; endproperty
  a_hold: assert property (p_hold) else $error("left sleep with select high");
  property p_wake; sleep_out && !cs_n_in |=> !sleep_out; endproperty
  a_wake: assert property (p_wake) else $error("no wake on select");
  property p_release; cs_n_in |=> serial_out_oe_n_out; endproperty
  a_release: assert property (p_release) else $error("serial out not released");
  property p_status; s_polled |-> serial_out_pin_out && !serial_out_oe_n_out; endproperty
  a_status: assert property (p_status) else $error("busy flag not shown");
  property p_sck_dir; !sck_oe_n_out |-> int_sck_mode_out && in_xfer && !$past(cs_n_in); endproperty
  a_sck_dir: assert property (p_sck_dir) else $error("shift clock driven out of turn");
  property p_full; in_xfer && rises == 5'h18 |-> ##[0:4] converting_out; endproperty
  a_full: assert property (p_full) else $error("no conversion after full word");
  property p_abort; s_cs_up ##0 (rises != 5'h0) |-> ##[1:4] converting_out; endproperty
  a_abort: assert property (p_abort) else $error("abort did not convert");
  property p_back; s_cs_up ##0 (rises == 5'h0) |-> ##[1:4] sleep_out; endproperty
  a_back: assert property (p_back) else $error("no return to sleep");
  property p_por; $rose(resetn_in) |-> route_out.pos_ch == 4'h0 && route_out.neg_ch == 4'h1; endproperty
  a_por: assert property (p_por) else $error("reset route wrong");
endmodule // asc_ctrl_assertions

// File: tb/tb_asc_ctrl.sv
// testbench: host model, sample source and checks around the controller
module tb_asc_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned CONV = 10;  // short count keeps the run brief
  logic mclk_in, resetn_in, f0, ext_run, sv, rdy, conv, slp, extc, intm, ok, sdo_lv;
  logic cs_n, serial_in_pin, sck_o, sck_oe_n, h_sck, h_oe_n, serial_out_pin, sdo_oe_n;
  logic [7:0]  sel;
  logic [23:0] w;
  int          seed, error_cnt, comparisons, cyc, i;
  asc_pkg::asc_sample_t smp;
  asc_pkg::asc_route_t  rt, prev_rt;
  asc_pkg::asc_sample_t q[$];
  wire sck_pin = !sck_oe_n ? sck_o : (!h_oe_n ? h_sck : 1'b1);  // pull-up when undriven
  wire sdo_pin = sdo_oe_n ? ~serial_out_pin : serial_out_pin;
  asc_ctrl #(.CONV_PERIODS(CONV), .FIFO_DEPTH(16)) u_asc_ctrl (
    .mclk_in(mclk_in), .resetn_in(resetn_in), .cs_n_in(cs_n), .sck_in(sck_pin), .sck_out(sck_o),
    .sck_oe_n_out(sck_oe_n), .serial_in_pin_in(serial_in_pin), .serial_out_pin_out(serial_out_pin), .serial_out_oe_n_out(sdo_oe_n),
    .conversion_clock_ctrl_pin_in(f0), .sample_in(smp), .sample_valid_in(sv), .sample_ready_out(rdy),
    .route_out(rt), .converting_out(conv), .sleep_out(slp), .ext_clk_out(extc), .int_sck_mode_out(intm));
  asc_host_model u_asc_host_model (.mclk_in(mclk_in), .sck_pin_in(sck_pin), .sdo_pin_in(sdo_pin),
    .cs_n_out(cs_n), .sck_drv_out(h_sck), .sck_oe_n_out(h_oe_n), .sdi_out(serial_in_pin));
  // ****************
  // clocks and tasks
  // ****************
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  initial begin
    f0 = 1'b0;
    forever begin
      repeat (8) @(negedge mclk_in);
      if (ext_run) f0 = ~f0;
    end
  end
  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic push();
    asc_pkg::asc_sample_t s;
    int r;
    r = $random(seed);
    if (q.size() < 2) r[17:16] = (q.size() == 0) ? 2'h3 : 2'h0;  // over and under first
    s = '{code: r[15:0], over: r[17:16] == 2'h3, under: r[17:16] == 2'h0};
    ok = rdy;
    sv = ok;  // held up across back-to-back pushes
    if (ok) begin
      smp = s;
      q.push_back(s);
    end
    @(negedge mclk_in);
  endtask
  task automatic wait_sleep();
    int k;
    for (k = 0; k < 20000 && slp !== 1'b1; k++) @(negedge mclk_in);
    check(24'(slp), 24'h1);
  endtask
  task automatic do_xfer(input bit ext, input int nb);
    logic [23:0] e, m;
    sel = 8'($random(seed));
    wait_sleep();
    prev_rt = rt;
    u_asc_host_model.xfer(ext, sel, nb, w, cyc);
    if (nb > 0) begin
      m = 24'hFFFFFF;
      e = q[0].over ? {asc_pkg::STAT_OVER, 22'h0} :
          q[0].under ? {asc_pkg::STAT_UNDER, 16'hFFFF, 6'h0} :
          {q[0].code[asc_pkg::CODE_W-1] ? asc_pkg::STAT_NEG : asc_pkg::STAT_POS, q[0].code, 6'h0};
      void'(q.pop_front());
      m = m >> (24 - nb);
      check(w & m, (e >> (24 - nb)) & m);
    end
    if (nb == 24) begin
      check(24'(rt.neg_is_shared), sel[7] ? 24'(sel[6]) : 24'(prev_rt.neg_is_shared));
      if (sel[7] && !sel[6]) check(24'(rt.pos_ch != rt.neg_ch), 24'h1);
      check(24'(rt.pos_ch), sel[7] ? 24'({sel[2:0], sel[5]}) : 24'(prev_rt.pos_ch));
    end
  endtask
  // ****************
  // test sequence
  // ****************
  initial begin
    seed = 32'h812C;
    error_cnt = 0;
    comparisons = 0;
    resetn_in = 1'b0;
    ext_run = 1'b0;
    sv = 1'b0;
    smp = '0;
    repeat (10) @(negedge mclk_in);
    resetn_in = 1'b1;
    @(negedge mclk_in);
    check({16'h0, rt.pos_ch, rt.neg_ch}, 24'h1);
    check(24'(conv), 24'h1);
    check(24'(intm), 24'h1);
    check(24'(sdo_oe_n), 24'h1);
    $display("test reset done");
    ok = 1'b1;
    while (ok && q.size() < 40) push();
    check(24'(rdy), 24'h0);  // full buffer refuses
    check(24'(q.size()), 24'h10);  // sixteen entries held
    $display("test buffer done");
    u_asc_host_model.hold_cs(1'b0, sdo_lv);
    check(24'(sdo_lv), 24'h1);
    check(24'(sdo_oe_n), 24'h0);
    u_asc_host_model.hold_cs(1'b1, sdo_lv);
    check(24'(sdo_oe_n), 24'h1);
    wait_sleep();
    repeat (50) @(negedge mclk_in);
    check(24'(slp), 24'h1);
    $display("test status done");
    for (i = 0; i < 10; i++) do_xfer(1'b1, 24);
    do_xfer(1'b1, 0);
    repeat (4) @(negedge mclk_in);
    check(24'(slp), 24'h1);
    do_xfer(1'b1, 24);
    do_xfer(1'b1, 1 + ($unsigned($random(seed)) % 20));
    check(24'(conv), 24'h1);
    $display("test transfers done");
    ext_run = 1'b1;
    repeat (100) @(negedge mclk_in);
    check(24'(extc), 24'h1);
    do_xfer(1'b0, 24);
    check(24'(intm), 24'h1);
    check(24'(cyc >= 2950 && cyc <= 3250), 24'h1);
    for (i = 0; i < 2000 && slp !== 1'b1; i++) @(negedge mclk_in);
    check(24'(i >= 120 && i <= 200), 24'h1);
    do_xfer(1'b1, 24);
    check(24'(intm), 24'h0);
    ext_run = 1'b0;
    repeat (1000) @(negedge mclk_in);
    check(24'(extc), 24'h0);
    $display("test clock modes done");
    complete_run();
  end
  initial begin
    repeat (80000) @(posedge mclk_in);
    error_cnt++;
    complete_run();
  end
endmodule // tb_asc_ctrl
bind asc_ctrl asc_ctrl_assertions #(.CONV_PERIODS(CONV_PERIODS), .FIFO_DEPTH(FIFO_DEPTH)) u_asc_ctrl_assertions (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .cs_n_in(cs_n_in), .sck_in(sck_in), .sck_oe_n_out(sck_oe_n_out),
  .serial_out_pin_out(serial_out_pin_out), .serial_out_oe_n_out(serial_out_oe_n_out), .route_out(route_out),
  .converting_out(converting_out), .sleep_out(sleep_out), .int_sck_mode_out(int_sck_mode_out));
